// ### shared/dgsm_cfg.svh
// constants for the dma global status and mode block
`ifndef DGSM_CFG_SVH
`define DGSM_CFG_SVH
`define DGSM_STATUS_OFFSET 6'h04
`define DGSM_MODE_OFFSET   6'h08
`define DGSM_RX_LSB        28
`define DGSM_TX_LSB        24
`define DGSM_CFG_BIT       21
`define DGSM_FAIL_BIT      1
`define DGSM_ACK_BIT       0
`define DGSM_MODE_BIT      0
`define DGSM_STATUS_RESET  32'h0000_0000
`define DGSM_MODE_RESET    1'b0
`define DGSM_STATUS_MASK   32'hff20_0003
`endif

// ### shared/dgsm_pkg.sv
// types for the dma global status and mode block
package dgsm_pkg;
	typedef struct packed {
		logic [31:0] status;
		logic        chain_end_select;
		logic [31:0] rdata;
		logic        irq;
	} dgsm_state_type;
endpackage : dgsm_pkg

// ### rtl/dgsm_top.sv
// global interrupt status and dma mode registers
`timescale 1ns/1ps
`default_nettype none
`include "dgsm_cfg.svh"
module dgsm_top #(
	parameter int NUM_CHANNELS = 4
) (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// register access
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [5:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	// queue write events, one-cycle pulses from the dma engine
	input  wire logic [3:0]  rx_vector_written_in,
	input  wire logic [3:0]  tx_vector_written_in,
	input  wire logic        cfg_vector_written_in,
	// action request outcome pulses
	input  wire logic        request_done_in,
	input  wire logic        request_failed_in,
	// mode and interrupt
	output logic             chain_end_select_out,
	output logic             int_a_n_out
);
	import dgsm_pkg::*;

	// ----------------------------------------
	// usage notes
	// ----------------------------------------
	// flags are sticky: an event pulse of one cycle is enough to set a
	// flag, and only a host write of one or a reset brings it back to zero.
	// a read and a write in the same cycle return the value from before
	// the write, so a host that reads back must use a later read.
	// the interrupt line is a registered level, one cycle behind the
	// event, which keeps it free of glitches on the bus side.
	// the mode bit only selects how chains end; the engine that walks
	// the descriptors lives outside this block.

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// flags that stand alone rather than in a four-bit group
	localparam logic [31:0] DGSM_SINGLE_FLAGS = (32'h1 << `DGSM_CFG_BIT)
		| (32'h1 << `DGSM_FAIL_BIT) | (32'h1 << `DGSM_ACK_BIT);

	// the status map has four bits per channel group; nothing else fits
	if (NUM_CHANNELS != 4) begin : g_bad_channels
		$error("dgsm_top supports exactly four channels");
	end

	// a set position outside the mask would swallow its event silently
	if (((`DGSM_STATUS_MASK >> `DGSM_RX_LSB) & 32'hf) != 32'hf) begin : g_rx
		$error("status mask hides a receive flag");
	end
	if (((`DGSM_STATUS_MASK >> `DGSM_TX_LSB) & 32'hf) != 32'hf) begin : g_tx
		$error("status mask hides a transmit flag");
	end
	if ((`DGSM_STATUS_MASK & DGSM_SINGLE_FLAGS) != DGSM_SINGLE_FLAGS)
	begin : g_single
		$error("status mask hides a single flag");
	end

	// the mode read word places the chain end bit at position zero
	if (`DGSM_MODE_BIT != 0) begin : g_mode_pos
		$error("mode bit must sit at position zero");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// true when the byte address names the given register
	function automatic logic dgsm_hit(
		input logic [5:0] addr,
		input logic [5:0] offset
	);
		dgsm_hit = (addr == offset);
	endfunction : dgsm_hit

	// one clock of a sticky flag word: host ones clear, then this cycle's
	// events are or-ed back in so a clear never eats a fresh event
	function automatic logic [31:0] dgsm_w1c_step(
		input logic [31:0] cur,
		input logic [31:0] clr,
		input logic [31:0] set,
		input logic [31:0] keep
	);
		dgsm_w1c_step = ((cur & ~clr) | set) & keep;
	endfunction : dgsm_w1c_step

	// read word of the mode register; only the chain end bit exists
	function automatic logic [31:0] dgsm_mode_word(input logic mode_bit);
		dgsm_mode_word = {31'h0, mode_bit};
	endfunction : dgsm_mode_word

	// ----------------------------------------
	// state update
	// ----------------------------------------
	dgsm_state_type state_reg;
	dgsm_state_type state_next;
	logic [31:0]    set_vec;
	logic [31:0]    clr_vec;
	logic           st_sel;
	logic           md_sel;
	logic [31:0]    status_word;

	// ----------------------------------------
	// named views of the flag fields
	// ----------------------------------------
	// the read word is rebuilt from these, so reserved positions are
	// wired to zero rather than trusting the mask alone
	logic rx_queue_flag_ch3;
	logic rx_queue_flag_ch2;
	logic rx_queue_flag_ch1;
	logic rx_queue_flag_ch0;
	logic tx_queue_flag_ch3;
	logic tx_queue_flag_ch2;
	logic tx_queue_flag_ch1;
	logic tx_queue_flag_ch0;
	logic config_queue_flag;
	logic request_failed_flag;
	logic request_done_flag;

	// receive queue flags, one per serial channel
	assign rx_queue_flag_ch3   = state_reg.status[`DGSM_RX_LSB + 3];
	assign rx_queue_flag_ch2   = state_reg.status[`DGSM_RX_LSB + 2];
	assign rx_queue_flag_ch1   = state_reg.status[`DGSM_RX_LSB + 1];
	assign rx_queue_flag_ch0   = state_reg.status[`DGSM_RX_LSB];
	// transmit queue flags, one per serial channel
	assign tx_queue_flag_ch3   = state_reg.status[`DGSM_TX_LSB + 3];
	assign tx_queue_flag_ch2   = state_reg.status[`DGSM_TX_LSB + 2];
	assign tx_queue_flag_ch1   = state_reg.status[`DGSM_TX_LSB + 1];
	assign tx_queue_flag_ch0   = state_reg.status[`DGSM_TX_LSB];
	// configuration queue and request outcome flags
	assign config_queue_flag   = state_reg.status[`DGSM_CFG_BIT];
	assign request_failed_flag = state_reg.status[`DGSM_FAIL_BIT];
	assign request_done_flag   = state_reg.status[`DGSM_ACK_BIT];

	// status read word; gaps between the groups are reserved zeros
	assign status_word = {
		rx_queue_flag_ch3, rx_queue_flag_ch2,
		rx_queue_flag_ch1, rx_queue_flag_ch0,
		tx_queue_flag_ch3, tx_queue_flag_ch2,
		tx_queue_flag_ch1, tx_queue_flag_ch0,
		2'b00, config_queue_flag, 19'h0_0000,
		request_failed_flag, request_done_flag
	};

	// ----------------------------------------
	// next state
	// ----------------------------------------

	// hardware set events gathered into status positions
	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec[`DGSM_RX_LSB +: 4] = rx_vector_written_in;
		set_vec[`DGSM_TX_LSB +: 4] = tx_vector_written_in;
		set_vec[`DGSM_CFG_BIT]     = cfg_vector_written_in;
		set_vec[`DGSM_FAIL_BIT]    = request_failed_in;
		set_vec[`DGSM_ACK_BIT]     = request_done_in;
	end

	// address decode
	always_comb begin
		st_sel = 1'b0;
		md_sel = 1'b0;
		if (dgsm_hit(reg_addr_in, `DGSM_STATUS_OFFSET)) begin
			st_sel = 1'b1;
		end else if (dgsm_hit(reg_addr_in, `DGSM_MODE_OFFSET)) begin
			md_sel = 1'b1;
		end
	end

	// write-one-to-clear, set wins; reads return registered data
	always_comb begin
		state_next = state_reg;
		clr_vec = (reg_wr_in && st_sel) ? reg_wdata_in : 32'h0000_0000;
		state_next.status = dgsm_w1c_step(state_reg.status, clr_vec,
			set_vec, `DGSM_STATUS_MASK);
		if (reg_wr_in && md_sel) begin
			state_next.chain_end_select = reg_wdata_in[`DGSM_MODE_BIT];
		end
		if (reg_rd_in) begin
			if (st_sel) begin
				state_next.rdata = status_word;
			end else if (md_sel) begin
				// reserved mode bits read as zero
				state_next.rdata = dgsm_mode_word(state_reg.chain_end_select);
			end else begin
				state_next.rdata = 32'h0000_0000;
			end
		end
		// any queue indication set keeps the line low
		state_next.irq = |state_next.status;
	end

	// registers, all clear after reset
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg.status           <= `DGSM_STATUS_RESET;
			state_reg.chain_end_select <= `DGSM_MODE_RESET;
			state_reg.rdata            <= 32'h0000_0000;
			state_reg.irq              <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata_out        = state_reg.rdata;
	// low selects descriptor stop flags, high the last-address registers
	assign chain_end_select_out = state_reg.chain_end_select;
	assign int_a_n_out          = ~state_reg.irq;
endmodule : dgsm_top
`default_nettype wire

// ### dv/dgsm_monitor.sv
// checker on the status and mode ports
`timescale 1ns/1ps
`default_nettype none
module dgsm_monitor (
	input wire logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in, reg_rdata_out,
	input wire logic [3:0] rx_vector_written_in, tx_vector_written_in,
	input wire logic cfg_vector_written_in, chain_end_select_out, int_a_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// decoded strobes keep the properties short
	wire logic s_wr = reg_wr_in && reg_addr_in == 6'h04;
	wire logic m_wr = reg_wr_in && reg_addr_in == 6'h08;
	wire logic m_rd = reg_rd_in && reg_addr_in == 6'h08;
	wire logic q_ev = |{rx_vector_written_in, tx_vector_written_in,
		cfg_vector_written_in};
	property p_set; q_ev |=> !int_a_n_out; endproperty
	a_set: assert property (p_set) else $error("irq late");
	property p_keep; !int_a_n_out && !s_wr |=> !int_a_n_out; endproperty
	a_keep: assert property (p_keep) else $error("irq dropped");
	property p_mode; m_wr |=> chain_end_select_out == $past(reg_wdata_in[0]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode lost");
	property p_mkeep; !m_wr |=> $stable(chain_end_select_out); endproperty
	a_mkeep: assert property (p_mkeep) else $error("mode moved");
	property p_mrd; m_rd && !reg_wr_in |=>
		reg_rdata_out == {31'h0, $past(chain_end_select_out)}; endproperty
	a_mrd: assert property (p_mrd) else $error("mode read");
	property p_srd; reg_rd_in && reg_addr_in == 6'h04 |=>
		!(reg_rdata_out & 32'h00df_fffc); endproperty
	a_srd: assert property (p_srd) else $error("status reserved");
	property p_unm; reg_rd_in && !(reg_addr_in inside {6'h04, 6'h08}) |=>
		reg_rdata_out == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
endmodule : dgsm_monitor
bind dgsm_top dgsm_monitor u_mon (.*);
`default_nettype wire

// ### dv/dgsm_dma_model.sv
// dma engine stand-in that launches event pulses
`timescale 1ns/1ps
`default_nettype none
module dgsm_dma_model (input wire logic clk_sys_in,
	input wire logic [10:0] ev_in, output logic [10:0] ev_out);
	// one-clock delay of ev_in, so a bit stays up exactly as long as ev_in holds it
	always_ff @(posedge clk_sys_in) ev_out <= ev_in;
endmodule : dgsm_dma_model
`default_nettype wire

// ### dv/dgsm_top_tb_top.sv
// bench for the global status and mode block
`timescale 1ns/1ps
`default_nettype none
module dgsm_top_tb_top;
	logic clk_sys_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [5:0] reg_addr_in = 0;
	logic [31:0] reg_wdata_in = 0, reg_rdata_out, m;
	logic [10:0] ev = 0, ev_out;
	logic int_a_n_out, chain_end_select_out;
	int err_total = 0, total_checks = 0;
	dgsm_dma_model MDL (.clk_sys_in, .ev_in(ev), .ev_out);
	dgsm_top DUT (.rx_vector_written_in(ev_out[10:7]),
		.tx_vector_written_in(ev_out[6:3]), .cfg_vector_written_in(ev_out[2]),
		.request_failed_in(ev_out[1]), .request_done_in(ev_out[0]), .*);
	initial forever #50 clk_sys_in = ~clk_sys_in;
	task chk(string n, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// one register cycle; a read compares against d
	task acc(logic w, logic [5:0] a, logic [31:0] d);
		@(posedge clk_sys_in);
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {w, !w, a, d};
		@(posedge clk_sys_in);
		{reg_wr_in, reg_rd_in} <= 2'h0;
		#1 if (!w) chk("rdata", d, reg_rdata_out);
	endtask : acc
	task pulse(logic [10:0] v);
		@(posedge clk_sys_in);
		ev <= v;
		@(posedge clk_sys_in);
		ev <= 11'h0;
	endtask : pulse
	task end_sim;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1;
		acc(0, 6'h04, 32'h0);
		acc(0, 6'h08, 32'h0);
		for (int i = 0; i < 11; i++) begin
			m = {19'h0, 11'h1 << i, 2'h0};
			m = {m[12:5], 2'h0, m[4], 19'h0, m[3:2]};
			pulse(11'h1 << i);
			acc(1, 6'h04, ~m);
			acc(0, 6'h04, m);
			if (i > 1) chk("irq", 32'h0, int_a_n_out);
			// set and clear land on the same edge
			fork
				pulse(11'h1 << i);
				begin
					@(posedge clk_sys_in);
					acc(1, 6'h04, m);
				end
			join
			acc(0, 6'h04, m);
			acc(1, 6'h04, m);
			acc(0, 6'h04, 32'h0);
			chk("irq", 32'h1, int_a_n_out);
		end
		$display("test events done");
		acc(1, 6'h08, 32'hffff_ffff);
		acc(0, 6'h08, 32'h1);
		chk("mode", 32'h1, chain_end_select_out);
		acc(1, 6'h08, 32'h0);
		chk("mode", 32'h0, chain_end_select_out);
		pulse(11'h3);
		acc(0, 6'h04, 32'h0000_0003);
		acc(1, 6'h04, 32'h0000_0003);
		acc(0, 6'h04, 32'h0);
		acc(1, 6'h0c, 32'hffff_ffff);
		acc(0, 6'h0c, 32'h0);
		$display("test mode done");
		end_sim;
	end
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
endmodule : dgsm_top_tb_top
`default_nettype wire
